// [rmp_defines.svh]
// register offsets, reset values and timing counts for the reference monitor profile bank
// assumes a byte-wide register port addressed by the 16-bit register offset
`ifndef RMP_DEFINES_SVH
`define RMP_DEFINES_SVH
`define RMP_OFF_PERIOD_B0    16'h0700
`define RMP_OFF_PERIOD_B4    16'h0704
`define RMP_OFF_INNER_B0     16'h0705
`define RMP_OFF_INNER_B1     16'h0706
`define RMP_OFF_INNER_B2     16'h0707
`define RMP_OFF_OUTER_B0     16'h0708
`define RMP_OFF_OUTER_B1     16'h0709
`define RMP_OFF_OUTER_B2     16'h070A
`define RMP_OFF_VTIMER_LO    16'h070B
`define RMP_OFF_VTIMER_HI    16'h070C
`define RMP_OFF_SPARE        16'h070D
`define RMP_OFF_FILTER_SEL   16'h070E
`define RMP_RST_PERIOD       40'h00_0310_EAC9
`define RMP_RST_INNER        20'h00014
`define RMP_RST_OUTER        20'h0000A
`define RMP_RST_VTIMER       16'h000A
`define RMP_RST_FILTER_SEL   1'h0
`define RMP_FILTER_SEL_BIT   0
`define RMP_CLK_PERIOD_PS    4000
`define RMP_MS_PS            1000000000
`define RMP_CYCLES_PER_MS    (`RMP_MS_PS / `RMP_CLK_PERIOD_PS)
`define RMP_CLK_PERIOD_FS    40'h00_003D_0900
`endif

// [rmp_pkg.sv]
// types for the reference monitor profile bank
// assumes rmp_defines.svh for all numbers except the state codes, which are written here
package rmp_pkg;
    typedef enum logic [1:0] {
        RMP_ST_FAULT      = 2'b00,
        RMP_ST_VALIDATING = 2'b01,
        RMP_ST_VALID      = 2'b10
    } rmp_state_t;
endpackage : rmp_pkg

// [rmp_profile_regs.sv]
// profile register bank and frequency monitor for the first reference input
// assumes a one-cycle write strobe, reads answered registered one cycle later,
// and a one-cycle pulse on each rising edge of the reference as sampled by the system timebase
// Notes on behaviour
// (RL1) inner tolerance: 20 bits, three bytes, LSB first
// (RL2) tolerance N means one part in N
// (RL3) software keeps inner tolerance within 10..0xFFFFF
// (RL4) outer tolerance: 20 bits, default ten
// (RL5) software sets outer smaller than inner
// (RL6) period measured in system timebase cycles
// (RL7) valid after in-tolerance for timer milliseconds
// (RL8) bit 0 selects high margin filter
// (RL9) software picks high margin above 2 kHz
// (RL10) nominal period 40 bits in femtoseconds
// (RL11) fault outside outer, revalidate inside inner
`timescale 1ns/10ps
`include "rmp_defines.svh"
module rmp_profile_regs
    import rmp_pkg::*;
#(
    parameter int CYCLES_PER_MS = `RMP_CYCLES_PER_MS,
    parameter int MEAS_W        = 24
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset_n,
    input  wire logic [15:0] i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_ref_edge,
    output logic      [7:0]  o_reg_rdata,
    output logic             o_ref_valid,
    output logic             o_ref_fault,
    output logic             o_high_margin_filter_select
);
    // refuse widths and rates the monitor cannot serve
    generate
        if (CYCLES_PER_MS < 2 || MEAS_W < 8 || MEAS_W > 40) begin : g_bad_param
            $error("rmp_profile_regs: bad parameter");
        end
    endgenerate

    logic [39:0] period_ff,  nxt_period;
    logic [19:0] inner_ff,   nxt_inner;
    logic [19:0] outer_ff,   nxt_outer;
    logic [15:0] vtimer_ff,  nxt_vtimer;
    logic        filt_ff,    nxt_filt;
    logic [7:0]  rdata_ff,   nxt_rdata;

    // register writes and reads
    always_comb begin
        nxt_period = period_ff;
        nxt_inner  = inner_ff;
        nxt_outer  = outer_ff;
        nxt_vtimer = vtimer_ff;
        nxt_filt   = filt_ff;
        nxt_rdata  = rdata_ff;
        if (i_reg_wr) begin
            // (RL10) period bytes
            if (i_reg_addr >= `RMP_OFF_PERIOD_B0 && i_reg_addr <= `RMP_OFF_PERIOD_B4) begin
                nxt_period[8*(i_reg_addr[2:0]) +: 8] = i_reg_wdata;
            end
            case (i_reg_addr)
                // (RL1) inner tolerance bytes
                `RMP_OFF_INNER_B0:   nxt_inner[7:0]   = i_reg_wdata;
                `RMP_OFF_INNER_B1:   nxt_inner[15:8]  = i_reg_wdata;
                `RMP_OFF_INNER_B2:   nxt_inner[19:16] = i_reg_wdata[3:0];
                // (RL4) outer tolerance bytes
                `RMP_OFF_OUTER_B0:   nxt_outer[7:0]   = i_reg_wdata;
                `RMP_OFF_OUTER_B1:   nxt_outer[15:8]  = i_reg_wdata;
                `RMP_OFF_OUTER_B2:   nxt_outer[19:16] = i_reg_wdata[3:0];
                `RMP_OFF_VTIMER_LO:  nxt_vtimer[7:0]  = i_reg_wdata;
                `RMP_OFF_VTIMER_HI:  nxt_vtimer[15:8] = i_reg_wdata;
                // (RL8) filter select bit
                `RMP_OFF_FILTER_SEL: nxt_filt = i_reg_wdata[`RMP_FILTER_SEL_BIT];
                default: ;
            endcase
        end
        if (i_reg_rd) begin
            nxt_rdata = 8'h00;
            if (i_reg_addr >= `RMP_OFF_PERIOD_B0 && i_reg_addr <= `RMP_OFF_PERIOD_B4) begin
                nxt_rdata = period_ff[8*(i_reg_addr[2:0]) +: 8];
            end
            case (i_reg_addr)
                `RMP_OFF_INNER_B0:   nxt_rdata = inner_ff[7:0];
                `RMP_OFF_INNER_B1:   nxt_rdata = inner_ff[15:8];
                `RMP_OFF_INNER_B2:   nxt_rdata = {4'h0, inner_ff[19:16]};
                `RMP_OFF_OUTER_B0:   nxt_rdata = outer_ff[7:0];
                `RMP_OFF_OUTER_B1:   nxt_rdata = outer_ff[15:8];
                `RMP_OFF_OUTER_B2:   nxt_rdata = {4'h0, outer_ff[19:16]};
                `RMP_OFF_VTIMER_LO:  nxt_rdata = vtimer_ff[7:0];
                `RMP_OFF_VTIMER_HI:  nxt_rdata = vtimer_ff[15:8];
                `RMP_OFF_FILTER_SEL: nxt_rdata = {7'h00, filt_ff};
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            period_ff <= `RMP_RST_PERIOD;
            inner_ff  <= `RMP_RST_INNER;
            outer_ff  <= `RMP_RST_OUTER;
            vtimer_ff <= `RMP_RST_VTIMER;
            filt_ff   <= `RMP_RST_FILTER_SEL;
            rdata_ff  <= 8'h00;
        end else begin
            period_ff <= nxt_period;
            inner_ff  <= nxt_inner;
            outer_ff  <= nxt_outer;
            vtimer_ff <= nxt_vtimer;
            filt_ff   <= nxt_filt;
            rdata_ff  <= nxt_rdata;
        end
    end

    logic [MEAS_W-1:0] meas_cnt_ff, nxt_meas_cnt;
    logic [MEAS_W-1:0] meas_lat_ff, nxt_meas_lat;
    logic              meas_vld_ff, nxt_meas_vld;
    logic              seen_ff,     nxt_seen;
    logic [31:0]       ms_cnt_ff,   nxt_ms_cnt;
    logic [15:0]       vcnt_ff,     nxt_vcnt;
    rmp_state_t        state_ff,    nxt_state;
    logic              valid_ff,    nxt_valid;
    logic              fault_ff,    nxt_fault;

    // nominal period in timebase cycles and deviation limits
    logic [39:0] nom_cyc;
    logic [39:0] in_lim;
    logic [39:0] out_lim;
    logic [39:0] meas_ext;
    logic [39:0] dev;
    logic        in_inner;
    logic        in_outer;

    // (RL2) allowed deviation is nominal divided by n
    always_comb begin
        nom_cyc  = period_ff / `RMP_CLK_PERIOD_FS;
        in_lim   = (inner_ff == 20'h00000) ? nom_cyc : nom_cyc / {20'h00000, inner_ff};
        out_lim  = (outer_ff == 20'h00000) ? nom_cyc : nom_cyc / {20'h00000, outer_ff};
        meas_ext = 40'(meas_lat_ff);
        dev      = (meas_ext > nom_cyc) ? meas_ext - nom_cyc : nom_cyc - meas_ext;
        in_inner = dev <= in_lim;
        in_outer = dev <= out_lim;
    end

    // (RL6) period counted in system timebase cycles
    always_comb begin
        nxt_meas_cnt = (&meas_cnt_ff) ? meas_cnt_ff : meas_cnt_ff + 1'b1;
        nxt_meas_lat = meas_lat_ff;
        nxt_meas_vld = 1'b0;
        nxt_seen     = seen_ff;
        if (i_ref_edge) begin
            nxt_meas_cnt = '0;
            nxt_seen     = 1'b1;
            if (seen_ff) begin
                nxt_meas_lat = meas_cnt_ff + 1'b1;
                nxt_meas_vld = 1'b1;
            end
        end else if (&meas_cnt_ff) begin
            nxt_meas_lat = meas_cnt_ff;
            nxt_meas_vld = 1'b1;
        end
    end

    // (RL11) fault, validate, valid hysteresis
    always_comb begin
        nxt_state  = state_ff;
        nxt_ms_cnt = ms_cnt_ff;
        nxt_vcnt   = vcnt_ff;
        case (state_ff)
            RMP_ST_FAULT: begin
                if (meas_vld_ff && in_inner) begin
                    nxt_state  = RMP_ST_VALIDATING;
                    nxt_ms_cnt = 32'h0000_0000;
                    nxt_vcnt   = 16'h0000;
                end
            end
            RMP_ST_VALIDATING: begin
                // (RL7) count whole milliseconds
                if (meas_vld_ff && !in_inner) begin
                    nxt_state = RMP_ST_FAULT;
                end else if (vcnt_ff >= vtimer_ff) begin
                    nxt_state = RMP_ST_VALID;
                end else if (ms_cnt_ff == 32'(CYCLES_PER_MS - 1)) begin
                    nxt_ms_cnt = 32'h0000_0000;
                    nxt_vcnt   = vcnt_ff + 16'h0001;
                end else begin
                    nxt_ms_cnt = ms_cnt_ff + 32'h0000_0001;
                end
            end
            RMP_ST_VALID: begin
                if (meas_vld_ff && !in_outer) begin
                    nxt_state = RMP_ST_FAULT;
                end
            end
            default: nxt_state = RMP_ST_FAULT;
        endcase
        nxt_valid = (nxt_state == RMP_ST_VALID);
        nxt_fault = (nxt_state == RMP_ST_FAULT);
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meas_cnt_ff <= '0;
            meas_lat_ff <= '0;
            meas_vld_ff <= 1'b0;
            seen_ff     <= 1'b0;
            ms_cnt_ff   <= 32'h0000_0000;
            vcnt_ff     <= 16'h0000;
            state_ff    <= RMP_ST_FAULT;
            valid_ff    <= 1'b0;
            fault_ff    <= 1'b1;
        end else begin
            meas_cnt_ff <= nxt_meas_cnt;
            meas_lat_ff <= nxt_meas_lat;
            meas_vld_ff <= nxt_meas_vld;
            seen_ff     <= nxt_seen;
            ms_cnt_ff   <= nxt_ms_cnt;
            vcnt_ff     <= nxt_vcnt;
            state_ff    <= nxt_state;
            valid_ff    <= nxt_valid;
            fault_ff    <= nxt_fault;
        end
    end

    assign o_reg_rdata                 = rdata_ff;
    assign o_ref_valid                 = valid_ff;
    assign o_ref_fault                 = fault_ff;
    assign o_high_margin_filter_select = filt_ff;

    a_inner_write: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // (RL1)
        i_reg_wr && i_reg_addr == `RMP_OFF_INNER_B2 |=> inner_ff[19:16] == $past(i_reg_wdata[3:0]))
        else $error("inner tolerance top nibble not stored");
    a_outer_read: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // (RL4)
        i_reg_rd && i_reg_addr == `RMP_OFF_OUTER_B2 |=> o_reg_rdata[7:4] == 4'h0)
        else $error("outer tolerance reserved bits not zero");
    a_filter_sel: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // (RL8)
        i_reg_wr && i_reg_addr == `RMP_OFF_FILTER_SEL |=> o_high_margin_filter_select == $past(i_reg_wdata[0]))
        else $error("filter select output wrong");
    a_period_write: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // (RL10)
        i_reg_wr && i_reg_addr == `RMP_OFF_PERIOD_B0 |=> period_ff[7:0] == $past(i_reg_wdata))
        else $error("period byte not stored");
    a_valid_time: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // (RL7)
        $rose(valid_ff) |-> $past(vcnt_ff) >= $past(vtimer_ff))
        else $error("valid declared before timer ran out");
    a_fault_outer: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // (RL11)
        state_ff == RMP_ST_VALID && meas_vld_ff && !in_outer |=> fault_ff && !valid_ff)
        else $error("fault not flagged outside outer window");
    a_inner_start: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // (RL11)
        state_ff == RMP_ST_FAULT && meas_vld_ff && !in_inner |=> state_ff == RMP_ST_FAULT)
        else $error("validation started outside inner window");
    a_meas_latch: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // (RL6)
        i_ref_edge && seen_ff |=> meas_vld_ff && meas_lat_ff == $past(meas_cnt_ff) + 1'b1)
        else $error("period measurement wrong");
endmodule : rmp_profile_regs

// [rmp_ref_source.sv]
// reference input model: one edge pulse every i_period system timebase cycles
// assumes a period of zero means the reference is absent and no edges come
`timescale 1ns/10ps
module rmp_ref_source (
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset_n,
    input  wire logic [15:0] i_period,
    output logic             o_ref_edge
);
    logic [15:0] cnt_ff;
    always @(negedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_ff     <= 16'h0000;
            o_ref_edge <= 1'b0;
        end else begin
            o_ref_edge <= (i_period != 16'h0000) && (cnt_ff + 16'h0001 >= i_period);
            cnt_ff     <= (cnt_ff + 16'h0001 >= i_period) ? 16'h0000 : cnt_ff + 16'h0001;
        end
    end
endmodule : rmp_ref_source

// [tb.sv]
// self-checking bench for the reference monitor profile bank
// assumes the bank plus a reference edge source model on the monitor input
`timescale 1ns/10ps
module tb;
    import rmp_pkg::*;
    localparam int CPM = 10;
    localparam int PER_FS = 400000000;
    localparam int CLK_FS = 4000000;
    logic        i_ref_clk   = 1'b0;
    logic        i_reset_n   = 1'b0;
    logic [15:0] i_reg_addr  = 16'h0000;
    logic        i_reg_wr    = 1'b0;
    logic        i_reg_rd    = 1'b0;
    logic [7:0]  i_reg_wdata = 8'h00;
    logic        i_ref_edge;
    logic [7:0]  o_reg_rdata;
    logic        o_ref_valid;
    logic        o_ref_fault;
    logic        o_high_margin_filter_select;
    logic [15:0] ref_period  = 16'h0000;
    logic [7:0]  lfsr        = 8'h4E;
    logic [7:0]  b;
    int          fails       = 0;
    int          checks      = 0;
    int          n;
    int          nom;
    int          lim_in;
    int          lim_out;
    int          mdl [10];
    int          dflt [10]   = '{'h14, 0, 0, 'h0A, 0, 0, 'h0A, 0, 0, 0};
    int          msk [10]    = '{'hFF, 'hFF, 'h0F, 'hFF, 'hFF, 'h0F, 'hFF, 'hFF, 0, 1};
    always #2 i_ref_clk = ~i_ref_clk;
    rmp_profile_regs #(.CYCLES_PER_MS(CPM)) i_rmp_profile_regs (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
        .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
        .i_ref_edge(i_ref_edge), .o_reg_rdata(o_reg_rdata), .o_ref_valid(o_ref_valid),
        .o_ref_fault(o_ref_fault), .o_high_margin_filter_select(o_high_margin_filter_select));
    rmp_ref_source i_rmp_ref_source (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_period(ref_period),
        .o_ref_edge(i_ref_edge));
    task automatic wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    function automatic logic [7:0] lfsr_step();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction : lfsr_step
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        i_reg_addr  = a;
        i_reg_wdata = d;
        i_reg_wr    = 1'b1;
        @(negedge i_ref_clk);
        i_reg_wr    = 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
        @(negedge i_ref_clk);
        i_reg_addr = a;
        i_reg_rd   = 1'b1;
        @(negedge i_ref_clk);
        i_reg_rd   = 1'b0;
        @(negedge i_ref_clk);
        chk(what, exp, o_reg_rdata);
    endtask : rd
    task automatic do_reset();
        i_reset_n = 1'b0;
        repeat (5) @(negedge i_ref_clk);
        i_reset_n = 1'b1;
        for (int k = 0; k < 10; k++) mdl[k] = dflt[k];
    endtask : do_reset
    task automatic wait_for(input logic v, input logic f, input int p, input string what);
        for (int k = 0; k < 20; k++) repeat (p) @(negedge i_ref_clk);
        n = 0;
        while ({o_ref_valid, o_ref_fault} !== {v, f} && n < 3000) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk(what, {6'h00, v, f}, {6'h00, o_ref_valid, o_ref_fault});
        if (n >= 3000) wrap_up();
    endtask : wait_for
    initial begin
        do_reset();
        for (int k = 0; k < 10; k++) rd(16'h0705 + 16'(k), mdl[k][7:0], "reset value");
        for (int k = 0; k < 5; k++) rd(16'h0700 + 16'(k), 8'(40'h00_0310_EAC9 >> (8 * k)), "period reset");
        rd(16'h0715, 8'h00, "unmapped read");
        $display("test reset values done");
        for (int k = 0; k < 10; k++) begin
            b = lfsr_step();
            wr(16'h0705 + 16'(k), b);
            mdl[k] = b & msk[k];
        end
        wr(16'h0715, lfsr_step());
        for (int k = 0; k < 10; k++) rd(16'h0705 + 16'(k), mdl[k][7:0], "readback");
        rd(16'h0715, 8'h00, "unmapped write");
        chk("filter select", 8'(mdl[9] & 1), {7'h00, o_high_margin_filter_select});
        $display("test random access done");
        do_reset();
        chk("filter after reset", 8'h00, {7'h00, o_high_margin_filter_select});
        for (int k = 0; k < 5; k++) wr(16'h0700 + 16'(k), 8'((PER_FS >> (8 * k)) & 255));
        for (int k = 0; k < 5; k++) rd(16'h0700 + 16'(k), 8'((PER_FS >> (8 * k)) & 255), "period readback");
        // inner in range, outer below inner
        nom     = PER_FS / CLK_FS;
        lim_in  = nom / (mdl[0] + (mdl[1] << 8));
        lim_out = nom / (mdl[3] + (mdl[4] << 8));
        ref_period = 16'(nom + lim_in / 2);
        wait_for(1'b0, 1'b0, 0, "validating");
        n = 0;
        while (o_ref_valid !== 1'b1 && n < 3000) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk("validation time", 8'h01, 8'(n >= mdl[6] * CPM && n <= mdl[6] * CPM + 3 * nom));
        if (n >= 3000) wrap_up();
        $display("test validation done");
        ref_period = 16'((nom + (lim_in + lim_out) / 2));
        wait_for(1'b1, 1'b0, int'(ref_period), "between windows");
        ref_period = 16'(nom + lim_out + 5);
        wait_for(1'b0, 1'b1, 0, "outside outer");
        ref_period = 16'((nom + (lim_in + lim_out) / 2));
        wait_for(1'b0, 1'b1, int'(ref_period), "no revalidate");
        ref_period = 16'(nom - lim_in / 2);
        wait_for(1'b1, 1'b0, 0, "revalidated");
        $display("test monitor done");
        // high margin chosen for wide loop
        wr(16'h070E, 8'hFF);
        repeat (2) @(negedge i_ref_clk);
        chk("filter output", 8'h01, {7'h00, o_high_margin_filter_select});
        rd(16'h070E, 8'h01, "filter reserved bits");
        $display("test filter select done");
        wrap_up();
    end
endmodule : tb
